// ### logic/stepper_pkg.sv
// constants, types and register map of the stepper indexer
package stepper_pkg;

   // indexer table geometry
   localparam int unsigned POS_W = 5;
   localparam logic [4:0] HOME_POS = 5'h04;
   localparam logic [4:0] QUARTER_POS = 5'h08;
   localparam logic [3:0] EDGE_MAG = 4'h8;
   localparam int unsigned LEVEL_W = 8;

   // winding magnitude, percent of full scale, for 0 to 8 eighths
   localparam logic [7:0] MAG_TABLE [0:8] = '{
      8'h64, 8'h62, 8'h5C, 8'h53, 8'h47, 8'h38, 8'h26, 8'h14, 8'h00
   };

   // resolution select codes
   localparam logic [1:0] RES_FULL = 2'h0;
   localparam logic [1:0] RES_HALF = 2'h1;
   localparam logic [1:0] RES_QUARTER = 2'h2;
   localparam logic [1:0] RES_EIGHTH = 2'h3;

   // step size in table entries for each resolution
   localparam logic [4:0] STEP_FULL = 5'h08;
   localparam logic [4:0] STEP_HALF = 5'h04;
   localparam logic [4:0] STEP_QUARTER = 5'h02;
   localparam logic [4:0] STEP_EIGHTH = 5'h01;

   // number of overcurrent sense points, four transistors per bridge
   localparam int unsigned OC_W = 8;

   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

   // field positions
   localparam int unsigned CTRL_BLOCK_BIT = 0;
   localparam int unsigned ST_POS_LSB = 0;
   localparam int unsigned ST_DRV_LSB = 8;
   localparam int unsigned ST_OCP_BIT = 12;
   localparam int unsigned ST_HOME_BIT = 13;

   // interrupt event bits
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_OCP = 0;
   localparam int unsigned IRQ_THERM = 1;
   localparam int unsigned IRQ_SUPPLY = 2;
   localparam int unsigned IRQ_STEP = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;

   // drive state, in order of precedence
   typedef enum logic [2:0] {
      DRV_SLEEP = 3'b000,
      DRV_SUPPLY = 3'b001,
      DRV_THERM = 3'b010,
      DRV_OCP = 3'b011,
      DRV_CLEAR = 3'b100,
      DRV_OFF = 3'b101,
      DRV_ON = 3'b110
   } drive_state_t;

endpackage

// ### logic/step_sync.sv
// synchroniser and rising-edge detector for step and direction inputs
module step_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_i,
   input wire logic dir_i,
   output logic step_rise_o,
   output logic dir_o
);

   logic step_meta_q;
   logic step_sync_q;
   logic step_prev_q;
   logic dir_meta_q;
   logic dir_sync_q;

   // two-stage capture, first stage read only by second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_meta_q <= 1'b0;
         step_sync_q <= 1'b0;
         step_prev_q <= 1'b0;
         dir_meta_q <= 1'b0;
         dir_sync_q <= 1'b0;
      end else begin
         step_meta_q <= step_i;
         step_sync_q <= step_meta_q;
         step_prev_q <= step_sync_q;
         dir_meta_q <= dir_i;
         dir_sync_q <= dir_meta_q;
      end
   end

   // one pulse per synchronised rising edge
   assign step_rise_o = step_sync_q & ~step_prev_q;
   assign dir_o = dir_sync_q;

endmodule // step_sync

// ### logic/stepper_indexer.sv
// microstep indexer with protection gating and wishbone registers

// What this block does
// - eighth mode walks 32 states; coarser modes skip entries by 2, 4, 8
// - overcurrent latches bridges off until enable goes high then low
// - overcurrent event also returns the indexer to home
// - any overcurrent sense point, either direction, causes the shutdown
// - thermal trip disables drivers, homes indexer, resumes on its own
// - low supply disables bridges and charge pump, keeps clocks running, and homes indexer until it recovers
// - indexer clear low holds home and disables both bridges
// - step pulses are ignored while indexer clear is asserted
// - bridge enable low turns bridges on, high turns them off
// - indexer keeps stepping while bridges are disabled by enable
// - low-power input low stops bridges, charge pump and clocks
// - in low power every other host control and protection sense pin is ignored; wishbone writes still apply
// - each step rising edge moves the indexer one state
// - direction high steps forward, low steps backward
// - home is 45 degrees, both 71%; origin flag low only there
module stepper_indexer (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // host control pins
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic resolution_sel_hi_i,
   input wire logic resolution_sel_lo_i,
   input wire logic indexer_clear_n_i,
   input wire logic bridge_on_n_i,
   input wire logic low_power_n_i,
   // protection sense
   input wire logic [7:0] overcurrent_trip_i,
   input wire logic thermal_trip_i,
   input wire logic supply_low_lockout_i,
   // drive outputs
   output logic signed [7:0] winding_a_level_o,
   output logic signed [7:0] winding_b_level_o,
   output logic winding_a_out_en_o,
   output logic winding_b_out_en_o,
   output logic charge_pump_en_o,
   output logic clocks_run_o,
   output logic at_origin_n_o,
   output logic irq_o
);

   logic step_rise;
   logic dir_level;
   logic [1:0] res_sel;
   logic [4:0] pos_q;
   logic [4:0] pos_d;
   logic [4:0] step_size;
   logic ocp_hit;
   logic ocp_latch_q;
   logic ocp_armed_q;
   logic sw_block_q;
   logic step_ok;
   logic force_home;
   stepper_pkg::drive_state_t drive_d;
   stepper_pkg::drive_state_t drive_q;
   logic bridges_on_q;
   logic pump_on_q;
   logic clocks_on_q;
   logic origin_n_q;
   logic signed [7:0] level_a_q;
   logic signed [7:0] level_b_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_mask_q;
   logic [3:0] irq_event;
   logic therm_prev_q;
   logic supply_prev_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic bus_req;
   logic wr_now;

   // signed winding level for a table position
   function automatic logic signed [7:0] level_of(input logic [4:0] pos);
      logic [3:0] eighth;
      logic [3:0] rev;
      logic [7:0] mag;
      eighth = {1'b0, pos[2:0]};
      rev = stepper_pkg::EDGE_MAG - eighth;
      case (pos[4:3])
         2'h0: mag = stepper_pkg::MAG_TABLE[eighth];
         2'h1: mag = -stepper_pkg::MAG_TABLE[rev];
         2'h2: mag = -stepper_pkg::MAG_TABLE[eighth];
         default: mag = stepper_pkg::MAG_TABLE[rev];
      endcase
      return signed'(mag);
   endfunction

   step_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .step_i(step_i),
      .dir_i(dir_i),
      .step_rise_o(step_rise),
      .dir_o(dir_level)
   );

   assign ocp_hit = |overcurrent_trip_i;
   assign res_sel = {resolution_sel_hi_i, resolution_sel_lo_i};

   always_comb begin
      case (res_sel)
         stepper_pkg::RES_FULL: step_size = stepper_pkg::STEP_FULL;
         stepper_pkg::RES_HALF: step_size = stepper_pkg::STEP_HALF;
         stepper_pkg::RES_QUARTER: step_size = stepper_pkg::STEP_QUARTER;
         default: step_size = stepper_pkg::STEP_EIGHTH;
      endcase
   end

   always_comb begin
      if (!low_power_n_i) begin
         drive_d = stepper_pkg::DRV_SLEEP;
      end else if (supply_low_lockout_i) begin
         drive_d = stepper_pkg::DRV_SUPPLY;
      end else if (thermal_trip_i) begin
         drive_d = stepper_pkg::DRV_THERM;
      end else if (ocp_latch_q || ocp_hit) begin
         drive_d = stepper_pkg::DRV_OCP;
      end else if (!indexer_clear_n_i) begin
         drive_d = stepper_pkg::DRV_CLEAR;
      end else if (bridge_on_n_i || sw_block_q) begin
         drive_d = stepper_pkg::DRV_OFF;
      end else begin
         drive_d = stepper_pkg::DRV_ON;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_q <= stepper_pkg::DRV_CLEAR;
      end else begin
         drive_q <= drive_d;
      end
   end

   // home forcing conditions, none apply in low power
   // home on overcurrent
   assign force_home = low_power_n_i &
      (supply_low_lockout_i | thermal_trip_i | ocp_hit | ~indexer_clear_n_i);

   assign step_ok = step_rise & low_power_n_i & indexer_clear_n_i & ~force_home;

   always_comb begin
      pos_d = pos_q;
      if (force_home) begin
         pos_d = stepper_pkg::HOME_POS;
      end else if (step_ok) begin
         if (dir_level) begin
            pos_d = pos_q + step_size;
         end else begin
            pos_d = pos_q - step_size;
         end
      end
   end

   // position register wraps over 32 states
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_q <= stepper_pkg::HOME_POS;
      end else begin
         pos_q <= pos_d;
      end
   end

   // overcurrent latch and enable toggle release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ocp_latch_q <= 1'b0;
         ocp_armed_q <= 1'b0;
      end else if (!low_power_n_i || supply_low_lockout_i) begin
         ocp_latch_q <= ocp_latch_q;
         ocp_armed_q <= ocp_armed_q;
      end else if (ocp_hit) begin
         ocp_latch_q <= 1'b1;
         ocp_armed_q <= 1'b0;
      end else if (ocp_latch_q && bridge_on_n_i) begin
         ocp_armed_q <= 1'b1;
      end else if (ocp_latch_q && ocp_armed_q) begin
         ocp_latch_q <= 1'b0;
         ocp_armed_q <= 1'b0;
      end
   end

   // output gating per drive state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bridges_on_q <= 1'b0;
         pump_on_q <= 1'b1;
         clocks_on_q <= 1'b1;
      end else begin
         case (drive_d)
            stepper_pkg::DRV_SLEEP: begin
               bridges_on_q <= 1'b0;
               pump_on_q <= 1'b0;
               clocks_on_q <= 1'b0;
            end
            stepper_pkg::DRV_SUPPLY: begin
               bridges_on_q <= 1'b0;
               pump_on_q <= 1'b0;
               clocks_on_q <= 1'b1;
            end
            stepper_pkg::DRV_ON: begin
               bridges_on_q <= 1'b1;
               pump_on_q <= 1'b1;
               clocks_on_q <= 1'b1;
            end
            default: begin
               bridges_on_q <= 1'b0;
               pump_on_q <= 1'b1;
               clocks_on_q <= 1'b1;
            end
         endcase
      end
   end

   // winding levels and origin flag from the next position
   // origin flag low at home only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_a_q <= level_of(stepper_pkg::HOME_POS);
         level_b_q <= level_of(stepper_pkg::HOME_POS - stepper_pkg::QUARTER_POS);
         origin_n_q <= 1'b0;
      end else begin
         level_a_q <= level_of(pos_d);
         level_b_q <= level_of(pos_d - stepper_pkg::QUARTER_POS);
         origin_n_q <= (pos_d != stepper_pkg::HOME_POS);
      end
   end

   assign winding_a_level_o = level_a_q;
   assign winding_b_level_o = level_b_q;
   assign winding_a_out_en_o = bridges_on_q;
   assign winding_b_out_en_o = bridges_on_q;
   assign charge_pump_en_o = pump_on_q;
   assign clocks_run_o = clocks_on_q;
   assign at_origin_n_o = origin_n_q;

   // edge history for fault events
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         therm_prev_q <= 1'b0;
         supply_prev_q <= 1'b0;
      end else begin
         therm_prev_q <= thermal_trip_i;
         supply_prev_q <= supply_low_lockout_i;
      end
   end

   // interrupt events, none raised in low power
   always_comb begin
      irq_event = stepper_pkg::IRQ_RESET;
      irq_event[stepper_pkg::IRQ_OCP] = ocp_hit & ~ocp_latch_q & low_power_n_i;
      irq_event[stepper_pkg::IRQ_THERM] = thermal_trip_i & ~therm_prev_q & low_power_n_i;
      irq_event[stepper_pkg::IRQ_SUPPLY] = supply_low_lockout_i & ~supply_prev_q
         & low_power_n_i;
      irq_event[stepper_pkg::IRQ_STEP] = step_ok;
   end

   // wishbone request decode
   assign bus_req = cyc_i & stb_i;
   assign wr_now = bus_req & we_i & ack_q & sel_i[0];

   // sticky status, set wins over write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= stepper_pkg::IRQ_RESET;
      end else if (wr_now && adr_i == stepper_pkg::REG_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~dat_i[3:0]) | irq_event;
      end else begin
         irq_stat_q <= irq_stat_q | irq_event;
      end
   end

   // writable control and mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= stepper_pkg::IRQ_RESET;
         sw_block_q <= 1'b0;
      end else if (wr_now) begin
         if (adr_i == stepper_pkg::REG_CTRL) begin
            sw_block_q <= dat_i[stepper_pkg::CTRL_BLOCK_BIT];
         end else if (adr_i == stepper_pkg::REG_IRQ_MASK) begin
            irq_mask_q <= dat_i[3:0];
         end
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // read data captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req && !ack_q) begin
         rdata_q <= 32'h0000_0000;
         if (adr_i == stepper_pkg::REG_CTRL) begin
            rdata_q[stepper_pkg::CTRL_BLOCK_BIT] <= sw_block_q;
         end else if (adr_i == stepper_pkg::REG_STATUS) begin
            rdata_q[stepper_pkg::ST_POS_LSB +: 5] <= pos_q;
            rdata_q[stepper_pkg::ST_DRV_LSB +: 3] <= drive_q;
            rdata_q[stepper_pkg::ST_OCP_BIT] <= ocp_latch_q;
            rdata_q[stepper_pkg::ST_HOME_BIT] <= ~origin_n_q;
         end else if (adr_i == stepper_pkg::REG_IRQ_STAT) begin
            rdata_q[3:0] <= irq_stat_q;
         end else if (adr_i == stepper_pkg::REG_IRQ_MASK) begin
            rdata_q[3:0] <= irq_mask_q;
         end
      end
   end

   assign dat_o = rdata_q;
   assign ack_o = ack_q;

endmodule // stepper_indexer

// ### tb/stepper_indexer_chk.sv
// port checker of the stepper indexer
module stepper_indexer_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic indexer_clear_n_i,
   input wire logic bridge_on_n_i,
   input wire logic low_power_n_i,
   input wire logic [7:0] overcurrent_trip_i,
   input wire logic thermal_trip_i,
   input wire logic supply_low_lockout_i,
   input wire logic signed [7:0] winding_a_level_o,
   input wire logic signed [7:0] winding_b_level_o,
   input wire logic winding_a_out_en_o,
   input wire logic winding_b_out_en_o,
   input wire logic charge_pump_en_o,
   input wire logic clocks_run_o,
   input wire logic at_origin_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answer timing
   property p_ack_once; ack_o |=> !ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held too long");
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   // protection and control gating
   property p_origin; !at_origin_n_o |-> winding_a_level_o == 8'sh47
      && winding_b_level_o == 8'sh47; endproperty
   a_origin: assert property (p_origin) else $error("origin levels");
   property p_clear; !indexer_clear_n_i && low_power_n_i |=> !at_origin_n_o
      && !winding_a_out_en_o && !winding_b_out_en_o; endproperty
   a_clear: assert property (p_clear) else $error("clear not homing");
   property p_enable; bridge_on_n_i |=> !winding_a_out_en_o && !winding_b_out_en_o; endproperty
   a_enable: assert property (p_enable) else $error("bridge on while off");
   property p_sleep; !low_power_n_i |=> !clocks_run_o && !charge_pump_en_o
      && !winding_b_out_en_o; endproperty
   a_sleep: assert property (p_sleep) else $error("low power outputs");
   property p_freeze; !low_power_n_i && !rst_i |=> $stable(winding_a_level_o)
      && $stable(at_origin_n_o); endproperty
   a_freeze: assert property (p_freeze) else $error("moved in low power");
   property p_supply; supply_low_lockout_i && low_power_n_i |=> !at_origin_n_o
      && !charge_pump_en_o && !winding_a_out_en_o; endproperty
   a_supply: assert property (p_supply) else $error("supply lockout");
   property p_therm; thermal_trip_i && low_power_n_i |=> !at_origin_n_o
      && !winding_b_out_en_o; endproperty
   a_therm: assert property (p_therm) else $error("thermal shutdown");
   property p_ocp; (|overcurrent_trip_i) && low_power_n_i |=> !at_origin_n_o
      && !winding_a_out_en_o; endproperty
   a_ocp: assert property (p_ocp) else $error("overcurrent shutdown");
endmodule // stepper_indexer_chk

bind stepper_indexer stepper_indexer_chk chk (.*);

// ### tb/step_host.sv
// host model issuing step pulses with direction and resolution
module step_host (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic fwd_i,
   input wire logic [1:0] res_i,
   input wire logic [5:0] count_i,
   input wire logic [3:0] width_i,
   output logic step_o,
   output logic dir_o,
   output logic res_hi_o,
   output logic res_lo_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] left_q;
   logic [3:0] tick_q;
   // idle levels
   initial begin
      {step_o, dir_o, res_hi_o, res_lo_o, busy_o} = 5'b01110;
      left_q = 6'h00;
      tick_q = 4'h0;
   end
   // pulse train, direction set a full width before the first rise
   always @(posedge clk_i) begin
      if (go_i && !busy_o) begin
         {res_hi_o, res_lo_o} <= res_i;
         dir_o <= fwd_i;
         left_q <= count_i;
         tick_q <= 4'h0;
         busy_o <= 1'b1;
      end else if (busy_o) begin
         if (tick_q == width_i) begin
            tick_q <= 4'h1;
            step_o <= !step_o;
            if (step_o) begin
               left_q <= left_q - 6'h01;
               busy_o <= left_q != 6'h01;
            end
         end else begin
            tick_q <= tick_q + 4'h1;
         end
      end
   end
endmodule // step_host

// ### tb/stepper_indexer_bench.sv
// self-checking bench of the stepper indexer
module stepper_indexer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic [3:0] sel_i = 4'hF;
   logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
   logic step_i, dir_i, resolution_sel_hi_i, resolution_sel_lo_i;
   logic indexer_clear_n_i = 1'b0, bridge_on_n_i = 1'b1, low_power_n_i = 1'b1;
   logic [7:0] overcurrent_trip_i = 8'h00;
   logic thermal_trip_i = 1'b0, supply_low_lockout_i = 1'b0;
   logic signed [7:0] winding_a_level_o, winding_b_level_o;
   logic winding_a_out_en_o, winding_b_out_en_o, charge_pump_en_o, clocks_run_o;
   logic at_origin_n_o, irq_o, go = 1'b0, fwd = 1'b1, busy;
   logic [1:0] res = 2'h3;
   logic [5:0] cnt = 6'h01;
   logic [3:0] wid = 4'h4;
   logic signed [7:0] tab [0:8] = '{8'h64, 8'h62, 8'h5C, 8'h53, 8'h47, 8'h38, 8'h26, 8'h14, 8'h00};
   int num_errors = 0, total_checks = 0;
   logic [31:0] q;

   stepper_indexer uut (.*);
   step_host host (.clk_i(clk_i), .go_i(go), .fwd_i(fwd), .res_i(res), .count_i(cnt),
      .width_i(wid), .step_o(step_i), .dir_o(dir_i), .res_hi_o(resolution_sel_hi_i),
      .res_lo_o(resolution_sel_lo_i), .busy_o(busy));

   // clock
   always #20 clk_i = ~clk_i;

   // winding A level of a table index, B trails by eight entries
   function automatic logic signed [7:0] lvl(input int i);
      int k;
      k = i & 7;
      case ((i >> 3) & 3)
         0: return tab[k];
         1: return -tab[8 - k];
         2: return -tab[k];
         default: return tab[8 - k];
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkpos(input int i);
      chk(winding_a_level_o, lvl(i));
      chk(winding_b_level_o, lvl(i + 24));
      chk(at_origin_n_o, i != 4);
   endtask

   // one classic bus cycle, started just after an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr_i <= a;
      dat_i <= d;
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      if (n >= 50) num_errors++;
      {cyc_i, stb_i, we_i} <= 3'b000;
      @(posedge clk_i);
   endtask

   task automatic mv(input logic [1:0] r, input logic f, input int n);
      int t;
      t = 0;
      {res, fwd, cnt, go} <= {r, f, 6'(n), 1'b1};
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy !== 1'b0 && t < 900) begin
         @(posedge clk_i);
         t++;
      end
      if (t >= 900) num_errors++;
      @(posedge clk_i);
   endtask

   task automatic t_reset();
      chkpos(4);
      chk({winding_a_out_en_o, charge_pump_en_o, clocks_run_o, irq_o}, 4'h6);
      wb(1'b0, stepper_pkg::REG_STATUS, 32'h0);
      chk(q, 32'h0000_2404);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      indexer_clear_n_i <= 1'b1;
   endtask

   task automatic t_modes();
      for (int r = 0; r < 4; r++) begin
         indexer_clear_n_i <= 1'b0;
         @(posedge clk_i);
         indexer_clear_n_i <= 1'b1;
         mv(2'(r), 1'b1, 2);
         chkpos(4 + 2 * (8 >> r));
         mv(2'(r), 1'b0, 3);
         chkpos((36 - (8 >> r)) % 32);
      end
   endtask

   task automatic t_clear_enable();
      {bridge_on_n_i, indexer_clear_n_i} <= 2'b00;
      mv(2'h3, 1'b1, 3);
      chkpos(4);
      chk(winding_a_out_en_o, 1'b0);
      indexer_clear_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({winding_a_out_en_o, winding_b_out_en_o}, 2'b11);
      bridge_on_n_i <= 1'b1;
      mv(2'h3, 1'b1, 2);
      chkpos(6);
      chk(winding_b_out_en_o, 1'b0);
      bridge_on_n_i <= 1'b0;
      // software block bit, ignored without byte enable
      sel_i <= 4'h0;
      wb(1'b1, stepper_pkg::REG_CTRL, 32'h1);
      sel_i <= 4'hF;
      wb(1'b0, stepper_pkg::REG_CTRL, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, stepper_pkg::REG_CTRL, 32'h1);
      @(posedge clk_i);
      chk(winding_a_out_en_o, 1'b0);
      wb(1'b0, stepper_pkg::REG_CTRL, 32'h0);
      chk(q, 32'h1);
      wb(1'b1, stepper_pkg::REG_CTRL, 32'h0);
      @(posedge clk_i);
      chk(winding_a_out_en_o, 1'b1);
   endtask

   task automatic t_ocp();
      wb(1'b1, stepper_pkg::REG_IRQ_MASK, 32'h1);
      for (int b = 0; b < 8; b += 7) begin
         mv(2'h3, 1'b1, 1);
         overcurrent_trip_i <= 8'h01 << b;
         @(posedge clk_i);
         overcurrent_trip_i <= 8'h00;
         repeat (3) @(posedge clk_i);
         chkpos(4);
         chk({winding_a_out_en_o, irq_o}, 2'b01);
         wb(1'b1, stepper_pkg::REG_IRQ_MASK, 32'h0);
         chk(irq_o, 1'b0);
         wb(1'b1, stepper_pkg::REG_IRQ_MASK, 32'h1);
         bridge_on_n_i <= 1'b1;
         @(posedge clk_i);
         bridge_on_n_i <= 1'b0;
         repeat (4) @(posedge clk_i);
         chk({winding_a_out_en_o, irq_o}, 2'b11);
         wb(1'b1, stepper_pkg::REG_IRQ_STAT, 32'h1);
         chk(irq_o, 1'b0);
      end
   endtask

   task automatic t_fault();
      for (int f = 0; f < 2; f++) begin
         mv(2'h3, 1'b1, 1);
         {supply_low_lockout_i, thermal_trip_i} <= f ? 2'b10 : 2'b01;
         repeat (2) @(posedge clk_i);
         chkpos(4);
         chk(winding_a_out_en_o, 1'b0);
         if (f) chk(charge_pump_en_o, 1'b0);
         {supply_low_lockout_i, thermal_trip_i} <= 2'b00;
         repeat (3) @(posedge clk_i);
         chk({winding_a_out_en_o, charge_pump_en_o}, 2'b11);
         // fault rise and step events are sticky
         wb(1'b0, stepper_pkg::REG_IRQ_STAT, 32'h0);
         chk(q[3:1], f ? 3'b110 : 3'b101);
         wb(1'b1, stepper_pkg::REG_IRQ_STAT, 32'hF);
      end
   endtask

   task automatic t_sleep();
      mv(2'h3, 1'b1, 1);
      low_power_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({winding_a_out_en_o, charge_pump_en_o, clocks_run_o}, 3'b000);
      {overcurrent_trip_i, indexer_clear_n_i} <= 9'h120;
      mv(2'h3, 1'b1, 2);
      chkpos(5);
      {overcurrent_trip_i, indexer_clear_n_i} <= 9'h001;
      @(posedge clk_i);
      low_power_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({winding_a_out_en_o, clocks_run_o}, 2'b11);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      for (int i = 1; i <= 32; i++) begin
         mv(2'h3, 1'b1, 1);
         chkpos((4 + i) % 32);
      end
      wid <= 4'h9;
      t_modes();
      t_clear_enable();
      t_ocp();
      t_fault();
      t_sleep();
      report_and_stop();
   end

   // watchdog
   initial begin
      #400000;
      num_errors++;
      report_and_stop();
   end
endmodule // stepper_indexer_bench
